// ---- event_flag_group.sv ----
`timescale 1ns/1ps
module event_flag_group #(
	parameter logic [7:0] IMPL_MASK = 8'hFF
) (
	input wire logic pclk, // Core clock
	input wire logic presetn, // Async reset, active low
	input wire logic [7:0] event_pulse, // Hardware events, one bit per source
	input wire logic enable_we, // Write strobe for enables
	input wire logic flag_we, // Write strobe for flags
	input wire logic [7:0] wdata, // Write byte
	output logic [7:0] enable, // Enable bits
	output logic [7:0] flag, // Flag bits
	output logic pending // Any flag and enable pair set
);
	irq_bank_pkg::flag_bank_s state;
	irq_bank_pkg::flag_bank_s next_state;

	always_comb begin
		next_state = state;
		if (enable_we) begin
			next_state.enable = wdata & IMPL_MASK;
		end
		if (flag_we) begin
			next_state.flag = wdata & IMPL_MASK;
		end
		// Hardware set wins over a clearing write in the same cycle
		next_state.flag = next_state.flag | (event_pulse & IMPL_MASK);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '{enable: irq_bank_pkg::RESET_BYTE, flag: irq_bank_pkg::RESET_BYTE};
		end else begin
			state <= next_state;
		end
	end

	assign enable = state.enable;
	assign flag = state.flag;
	assign pending = |(state.enable & state.flag);

	AST_EVENT_SETS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		(event_pulse & IMPL_MASK) != 8'h00 |=> ((flag & $past(event_pulse & IMPL_MASK))
		== $past(event_pulse & IMPL_MASK))) else $error("event did not set flag");
	AST_UNIMPL_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		((enable | flag) & ~IMPL_MASK) == 8'h00) else $error("unimplemented bit set");
	AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
		!flag_we |=> (($past(flag) & ~flag) == 8'h00)) else $error("flag cleared by itself");

endmodule : event_flag_group

// ---- event_source_model.sv ----
`timescale 1ns/1ps
module event_source_model (
	input wire logic pclk, // Core clock
	input wire logic presetn, // Async reset, active low
	input wire logic [12:0] trig, // One-cycle request, one bit per source
	output logic [12:0] ev // Event levels toward the bank
);
	// ==========================================================
	// Source levels
	// Held three clocks, one more than the bank's sync chain needs to see an edge
	logic [1:0] hold;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev <= 13'h0000;
			hold <= 2'h0;
		end else if (|trig) begin
			ev <= trig;
			hold <= 2'h2;
		end else if (hold != 2'h0) begin
			hold <= hold - 2'h1;
		end else begin
			ev <= 13'h0000;
		end
	end
endmodule : event_source_model

// ---- event_sync.sv ----
`timescale 1ns/1ps
module event_sync #(
	parameter int WIDTH = 14
) (
	input wire logic pclk, // Core clock
	input wire logic presetn, // Async reset, active low
	input wire logic [WIDTH-1:0] level_in, // Raw event levels from sources
	output logic [WIDTH-1:0] rise // One-cycle pulse on each rising edge
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] last;
	} sync_s;

	sync_s state;
	sync_s next_state;

	always_comb begin
		next_state.meta = level_in;
		next_state.sync = state.meta;
		next_state.last = state.sync;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Edge detect reads only the second and third stages
	assign rise = state.sync & ~state.last;

endmodule : event_sync

// ---- irq_bank_pkg.sv ----
package irq_bank_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_ENABLE_A = 12'h004;
	localparam logic [11:0] ADDR_ENABLE_B = 12'h008;
	localparam logic [11:0] ADDR_FLAG_A = 12'h00C;
	localparam logic [11:0] ADDR_FLAG_B = 12'h010;
	localparam logic [11:0] ADDR_STATUS = 12'h014;

	// ==========================================================
	// Implemented bit masks
	localparam logic [7:0] MASK_A = 8'h7F;
	localparam logic [7:0] MASK_B = 8'h9F;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ==========================================================
	// Control register bit positions
	localparam int BIT_GLOBAL = 1;
	localparam int BIT_PERIPH = 0;

	// ==========================================================
	// Source bit positions, group a
	localparam int BIT_ADC = 6;
	localparam int BIT_BUS_COLLISION = 5;
	localparam int BIT_SERIAL_PORT = 4;
	localparam int BIT_CAPCMP2 = 3;
	localparam int BIT_CAPCMP1 = 2;
	localparam int BIT_TIMER2 = 1;
	localparam int BIT_TIMER1 = 0;

	// ==========================================================
	// Source bit positions, group b
	localparam int BIT_DESAT = 7;
	localparam int BIT_OVERTEMP = 4;
	localparam int BIT_OUT_OVERVOLT = 3;
	localparam int BIT_GATE_DRIVE_UV = 2;
	localparam int BIT_IN_OVERVOLT = 1;
	localparam int BIT_IN_UNDERVOLT = 0;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] flag;
	} flag_bank_s;

endpackage : irq_bank_pkg

// ---- periph_irq_bank.sv ----
// Functional notes
// - Peripheral request needs group enable bit set
// - Flags set on events regardless of enables
// - Enable a: ADC, collision, serial, cc2, cc1, t2, t1
// - Unimplemented bits always read zero
// - Enable b: desat, temp, ovout, drvuv, ovin, uvin
// - Flag a mirrors enable a; ADC on conversion
// - Collision and serial flags mark pending interrupt
// - Capture/compare units set bits 3 and 2
// - Timer1 rollover sets bit 0, never auto-cleared
// - Global enable gates every request to CPU
// - Flag b mirrors enable b positions
`timescale 1ns/1ps
module periph_irq_bank (
	input wire logic pclk, // Core clock, 40 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic adc_done, // ADC conversion complete
	input wire logic bus_collision, // Serial port bus collision
	input wire logic serial_port_event, // Serial port unit event
	input wire logic capcmp2_event, // Capture/compare 2 event
	input wire logic capcmp1_event, // Capture/compare 1 event
	input wire logic timer2_match, // Timer2 matched its period register
	input wire logic timer1_rollover, // Timer1 rolled over
	input wire logic desat_event, // Desaturation detect comparator
	input wire logic overtemp_event, // Overtemperature
	input wire logic out_overvolt_event, // Output overvoltage edge
	input wire logic gate_drive_uv_event, // Gate drive undervoltage lockout
	input wire logic in_overvolt_event, // Input overvoltage edge
	input wire logic in_undervolt_event, // Input undervoltage edge
	output logic periph_irq, // Peripheral group request
	output logic cpu_irq // Request to CPU, global gated
);
	// ==========================================================
	// State
	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_group_enable;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic periph_irq;
		logic cpu_irq;
	} top_s;

	top_s state;
	top_s next_state;

	logic [12:0] raw_events;
	logic [12:0] rise;
	logic [7:0] events_a;
	logic [7:0] events_b;
	logic [7:0] peripheral_irq_enable_a;
	logic [7:0] peripheral_irq_flag_a;
	logic [7:0] peripheral_irq_enable_b;
	logic [7:0] peripheral_irq_flag_b;
	logic pending_a;
	logic pending_b;
	logic setup;
	logic wr_en;
	logic mapped;
	logic we_enable_a;
	logic we_flag_a;
	logic we_enable_b;
	logic we_flag_b;

	// ==========================================================
	// Event capture
	// Sources are treated as asynchronous levels; a pulse shorter than two
	// clocks may be missed, so sources must hold their event for that long.
	assign raw_events = {
		in_undervolt_event,
		in_overvolt_event,
		gate_drive_uv_event,
		out_overvolt_event,
		overtemp_event,
		desat_event,
		timer1_rollover,
		timer2_match,
		capcmp1_event,
		capcmp2_event,
		serial_port_event,
		bus_collision,
		adc_done
	};

	event_sync #(
		.WIDTH(13)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.level_in(raw_events),
		.rise(rise)
	);

	always_comb begin
		events_a = 8'h00;
		events_a[irq_bank_pkg::BIT_ADC] = rise[0];
		events_a[irq_bank_pkg::BIT_BUS_COLLISION] = rise[1];
		events_a[irq_bank_pkg::BIT_SERIAL_PORT] = rise[2];
		events_a[irq_bank_pkg::BIT_CAPCMP2] = rise[3];
		events_a[irq_bank_pkg::BIT_CAPCMP1] = rise[4];
		events_a[irq_bank_pkg::BIT_TIMER2] = rise[5];
		events_a[irq_bank_pkg::BIT_TIMER1] = rise[6];
		events_b = 8'h00;
		events_b[irq_bank_pkg::BIT_DESAT] = rise[7];
		events_b[irq_bank_pkg::BIT_OVERTEMP] = rise[8];
		events_b[irq_bank_pkg::BIT_OUT_OVERVOLT] = rise[9];
		events_b[irq_bank_pkg::BIT_GATE_DRIVE_UV] = rise[10];
		events_b[irq_bank_pkg::BIT_IN_OVERVOLT] = rise[11];
		events_b[irq_bank_pkg::BIT_IN_UNDERVOLT] = rise[12];
	end

	// ==========================================================
	// APB decode
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && state.pready;
	assign mapped = (paddr == irq_bank_pkg::ADDR_CONTROL) || (paddr == irq_bank_pkg::ADDR_ENABLE_A)
		|| (paddr == irq_bank_pkg::ADDR_ENABLE_B) || (paddr == irq_bank_pkg::ADDR_FLAG_A)
		|| (paddr == irq_bank_pkg::ADDR_FLAG_B) || (paddr == irq_bank_pkg::ADDR_STATUS);
	assign we_enable_a = wr_en && (paddr == irq_bank_pkg::ADDR_ENABLE_A);
	assign we_flag_a = wr_en && (paddr == irq_bank_pkg::ADDR_FLAG_A);
	assign we_enable_b = wr_en && (paddr == irq_bank_pkg::ADDR_ENABLE_B);
	assign we_flag_b = wr_en && (paddr == irq_bank_pkg::ADDR_FLAG_B);

	// ==========================================================
	// Flag banks
	event_flag_group #(
		.IMPL_MASK(irq_bank_pkg::MASK_A)
	) u_group_a (
		.pclk(pclk),
		.presetn(presetn),
		.event_pulse(events_a),
		.enable_we(we_enable_a),
		.flag_we(we_flag_a),
		.wdata(pwdata[7:0]),
		.enable(peripheral_irq_enable_a),
		.flag(peripheral_irq_flag_a),
		.pending(pending_a)
	);

	event_flag_group #(
		.IMPL_MASK(irq_bank_pkg::MASK_B)
	) u_group_b (
		.pclk(pclk),
		.presetn(presetn),
		.event_pulse(events_b),
		.enable_we(we_enable_b),
		.flag_we(we_flag_b),
		.wdata(pwdata[7:0]),
		.enable(peripheral_irq_enable_b),
		.flag(peripheral_irq_flag_b),
		.pending(pending_b)
	);

	// ==========================================================
	// Control, read path and request outputs
	always_comb begin
		next_state = state;
		next_state.pready = setup;
		next_state.pslverr = setup && !mapped;
		if (setup) begin
			next_state.prdata = 32'h0000_0000;
			unique case (paddr)
				irq_bank_pkg::ADDR_CONTROL: begin
					next_state.prdata[irq_bank_pkg::BIT_GLOBAL] = state.global_irq_enable;
					next_state.prdata[irq_bank_pkg::BIT_PERIPH] =
						state.peripheral_group_enable;
				end
				irq_bank_pkg::ADDR_ENABLE_A: next_state.prdata[7:0] = peripheral_irq_enable_a;
				irq_bank_pkg::ADDR_ENABLE_B: next_state.prdata[7:0] = peripheral_irq_enable_b;
				irq_bank_pkg::ADDR_FLAG_A: next_state.prdata[7:0] = peripheral_irq_flag_a;
				irq_bank_pkg::ADDR_FLAG_B: next_state.prdata[7:0] = peripheral_irq_flag_b;
				irq_bank_pkg::ADDR_STATUS: begin
					next_state.prdata[1] = state.cpu_irq;
					next_state.prdata[0] = state.periph_irq;
				end
				default: next_state.prdata = 32'h0000_0000;
			endcase
		end
		if (wr_en && (paddr == irq_bank_pkg::ADDR_CONTROL)) begin
			next_state.global_irq_enable = pwdata[irq_bank_pkg::BIT_GLOBAL];
			next_state.peripheral_group_enable = pwdata[irq_bank_pkg::BIT_PERIPH];
		end
		// Gating uses the registered enables, so a write takes effect one clock later
		next_state.periph_irq = state.peripheral_group_enable && (pending_a || pending_b);
		next_state.cpu_irq = state.global_irq_enable && state.peripheral_group_enable
			&& (pending_a || pending_b);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign periph_irq = state.periph_irq;
	assign cpu_irq = state.cpu_irq;

	// ==========================================================
	// Request checks
	sequence s_armed;
		state.peripheral_group_enable && (pending_a || pending_b);
	endsequence

	AST_GROUP_GATES: assert property (@(posedge pclk) disable iff (!presetn)
		!state.peripheral_group_enable |=> !periph_irq)
		else $error("request without group");
	AST_REQUEST_RAISED: assert property (@(posedge pclk) disable iff (!presetn)
		s_armed |=> periph_irq)
		else $error("armed source gave no request");
	AST_GLOBAL_GATES: assert property (@(posedge pclk) disable iff (!presetn)
		!state.global_irq_enable |=> !cpu_irq)
		else $error("cpu request while global off");
	AST_CPU_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
		(s_armed ##0 state.global_irq_enable) |=> cpu_irq)
		else $error("cpu request missing");

	// ==========================================================
	// Bus checks
	sequence s_setup_at(logic [11:0] addr);
		setup && (paddr == addr);
	endsequence

	sequence s_write_at(logic [11:0] addr);
		wr_en && (paddr == addr);
	endsequence

	AST_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready)
		else $error("no ready after setup");
	AST_IDLE_NO_READY: assert property (@(posedge pclk) disable iff (!presetn)
		!setup |=> !pready)
		else $error("ready without setup");
	AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !mapped) |=> pslverr)
		else $error("unmapped access without error");
	AST_MAPPED_NO_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && mapped) |=> !pslverr)
		else $error("error on mapped access");
	AST_READ_UNIMPL: assert property (@(posedge pclk) disable iff (!presetn)
		s_setup_at(irq_bank_pkg::ADDR_ENABLE_B) |=> prdata[6:5] == 2'b00)
		else $error("unimplemented bits read nonzero");
	AST_FLAG_A_BIT7: assert property (@(posedge pclk) disable iff (!presetn)
		s_setup_at(irq_bank_pkg::ADDR_FLAG_A) |=> !prdata[7])
		else $error("flag a bit 7 read nonzero");
	AST_ENABLE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_at(irq_bank_pkg::ADDR_ENABLE_A) |=>
		peripheral_irq_enable_a == ($past(pwdata[7:0]) & irq_bank_pkg::MASK_A))
		else $error("enable a write lost");
	AST_ENABLE_B_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_at(irq_bank_pkg::ADDR_ENABLE_B) |=>
		peripheral_irq_enable_b == ($past(pwdata[7:0]) & irq_bank_pkg::MASK_B))
		else $error("enable b write lost");
	AST_CONTROL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_at(irq_bank_pkg::ADDR_CONTROL) |=>
		(state.global_irq_enable == $past(pwdata[irq_bank_pkg::BIT_GLOBAL]))
		&& (state.peripheral_group_enable == $past(pwdata[irq_bank_pkg::BIT_PERIPH])))
		else $error("control write lost");
	AST_FLAG_A_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		(we_flag_a && (events_a == 8'h00)) |=>
		peripheral_irq_flag_a == ($past(pwdata[7:0]) & irq_bank_pkg::MASK_A))
		else $error("flag a write lost");

	// ==========================================================
	// Event checks
	AST_ADC_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[0] |=> peripheral_irq_flag_a[irq_bank_pkg::BIT_ADC])
		else $error("adc flag not set");
	AST_COLLISION_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[1] |=> peripheral_irq_flag_a[irq_bank_pkg::BIT_BUS_COLLISION])
		else $error("collision flag not set");
	AST_SERIAL_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[2] |=> peripheral_irq_flag_a[irq_bank_pkg::BIT_SERIAL_PORT])
		else $error("serial flag not set");
	AST_CAPCMP2_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[3] |=> peripheral_irq_flag_a[irq_bank_pkg::BIT_CAPCMP2])
		else $error("capcmp2 flag not set");
	AST_CAPCMP1_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[4] |=> peripheral_irq_flag_a[irq_bank_pkg::BIT_CAPCMP1])
		else $error("capcmp1 flag not set");
	AST_TIMER2_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[5] |=> peripheral_irq_flag_a[irq_bank_pkg::BIT_TIMER2])
		else $error("timer2 flag not set");
	AST_TIMER1_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[6] |=> peripheral_irq_flag_a[irq_bank_pkg::BIT_TIMER1])
		else $error("timer1 flag not set");
	AST_DESAT_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[7] |=> peripheral_irq_flag_b[irq_bank_pkg::BIT_DESAT])
		else $error("desat flag not set");
	AST_OVERTEMP_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[8] |=> peripheral_irq_flag_b[irq_bank_pkg::BIT_OVERTEMP])
		else $error("overtemp flag not set");
	AST_OUT_OVERVOLT_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[9] |=> peripheral_irq_flag_b[irq_bank_pkg::BIT_OUT_OVERVOLT])
		else $error("output overvoltage flag not set");
	AST_GATE_UV_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rise[10] |=> peripheral_irq_flag_b[irq_bank_pkg::BIT_GATE_DRIVE_UV])
		else $error("gate drive undervoltage flag not set");

endmodule : periph_irq_bank

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	// ==========================================================
	// Signals
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic e;
	} row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, periph_irq, cpu_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [12:0] trig, ev;
	int error_cnt, checked;
	row_s rows[8];

	always #12.5 pclk = ~pclk;

	event_source_model i_event_source_model (.pclk(pclk), .presetn(presetn), .trig(trig),
		.ev(ev));
	periph_irq_bank i_periph_irq_bank (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adc_done(ev[6]), .bus_collision(ev[5]),
		.serial_port_event(ev[4]), .capcmp2_event(ev[3]), .capcmp1_event(ev[2]),
		.timer2_match(ev[1]), .timer1_rollover(ev[0]), .desat_event(ev[12]),
		.overtemp_event(ev[11]), .out_overvolt_event(ev[10]), .gate_drive_uv_event(ev[9]),
		.in_overvolt_event(ev[8]), .in_undervolt_event(ev[7]), .periph_irq(periph_irq),
		.cpu_irq(cpu_irq));

	// ==========================================================
	// Reporting
	task conclude;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %0t word got %h exp %h", $time, got, exp);
		end
	endtask : chk_word

	task chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %0t bit got %b exp %b", $time, got, exp);
		end
	endtask : chk_bit

	// ==========================================================
	// APB master
	// Request stands until pready is seen high at a rising edge; read data taken at that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("mismatch %0t pready timeout", $time);
			conclude();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk_word(q, exp);
	endtask : rd

	task fire(input logic [12:0] v);
		trig <= v;
		@(posedge pclk);
		trig <= 13'h0000;
		repeat (8) @(posedge pclk);
	endtask : fire

	task irq_is(input logic p, input logic c);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk_bit(periph_irq, p);
		chk_bit(cpu_irq, c);
		@(posedge pclk);
		rd(irq_bank_pkg::ADDR_STATUS, {30'h0, c, p});
	endtask : irq_is

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		conclude();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] q;
		logic e;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		trig = 13'h0000;
		error_cnt = 0;
		checked = 0;
		rows = '{'{irq_bank_pkg::ADDR_STATUS, 32'h000000FF, 32'h0, 1'b0},
			'{12'h018, 32'h000000FF, 32'h0, 1'b1},
			'{irq_bank_pkg::ADDR_CONTROL, 32'hFFFFFFFF, 32'h3, 1'b0},
			'{irq_bank_pkg::ADDR_ENABLE_A, 32'h000000FF, 32'h7F, 1'b0},
			'{irq_bank_pkg::ADDR_ENABLE_B, 32'h000000FF, 32'h9F, 1'b0},
			'{irq_bank_pkg::ADDR_FLAG_A, 32'h000000FF, 32'h7F, 1'b0},
			'{irq_bank_pkg::ADDR_FLAG_B, 32'h000000FF, 32'h9F, 1'b0},
			'{irq_bank_pkg::ADDR_ENABLE_A, 32'h000000AA, 32'h2A, 1'b0}};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 6; i++) begin
			rd(12'(4 * i), 32'h0);
		end
		for (int i = 0; i < 8; i++) begin
			wr(rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0, q, e);
			chk_word(q, rows[i].q);
			chk_bit(e, rows[i].e);
		end
		for (int i = 0; i < 5; i++) begin
			wr(12'(4 * i), 32'h0);
		end
		// One source at a time, all enables off
		for (int i = 0; i < 13; i++) begin
			fire(13'h0001 << i);
			rd(irq_bank_pkg::ADDR_FLAG_A, 32'h1 << i & 32'h7F);
			rd(irq_bank_pkg::ADDR_FLAG_B, i < 7 ? 32'h0 : i == 12 ? 32'h80 : 32'h1 << (i - 7));
			chk_bit(periph_irq, 1'b0);
			wr(irq_bank_pkg::ADDR_FLAG_A, 32'h0);
			wr(irq_bank_pkg::ADDR_FLAG_B, 32'h0);
		end
		fire(13'h1FFF);
		wr(irq_bank_pkg::ADDR_CONTROL, 32'h1);
		wr(irq_bank_pkg::ADDR_ENABLE_A, 32'h1);
		irq_is(1'b1, 1'b0);
		wr(irq_bank_pkg::ADDR_CONTROL, 32'h3);
		irq_is(1'b1, 1'b1);
		wr(irq_bank_pkg::ADDR_FLAG_A, 32'h7E);
		irq_is(1'b0, 1'b0);
		rd(irq_bank_pkg::ADDR_FLAG_A, 32'h7E);
		wr(irq_bank_pkg::ADDR_ENABLE_B, 32'h80);
		irq_is(1'b1, 1'b1);
		wr(irq_bank_pkg::ADDR_CONTROL, 32'h2);
		irq_is(1'b0, 1'b0);
		// Stale flag cleared before the group is armed again: no request may follow
		wr(irq_bank_pkg::ADDR_FLAG_B, 32'h0);
		wr(irq_bank_pkg::ADDR_CONTROL, 32'h3);
		irq_is(1'b0, 1'b0);
		fire(13'h1000);
		irq_is(1'b1, 1'b1);
		// Reset in mid-run clears everything again
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_bit(periph_irq, 1'b0);
		chk_bit(cpu_irq, 1'b0);
		rd(irq_bank_pkg::ADDR_FLAG_B, 32'h0);
		rd(irq_bank_pkg::ADDR_ENABLE_B, 32'h0);
		rd(irq_bank_pkg::ADDR_CONTROL, 32'h0);
		rd(irq_bank_pkg::ADDR_FLAG_A, 32'h0);
		conclude();
	end
endmodule : tb_top
